// file: core/fsf_top.v
// status flags, expansion outputs and register bus of the 18-bit fifo
// Notes on behaviour
// - empty output low while nothing stored; reads then refused; high otherwise.
// - empty output changes only on the clock edge of the read side.
// - almost-empty output low while stored count is at or below its offset.
// - almost-empty offset resets to 31, 63 or 127 by depth variant.
// - almost-full output low while free space is at or below its offset.
// - almost-full offset resets to 31, 63 or 127 by depth variant.
// - unchained, shared pin is half-full: low when over half occupied.
// - chained, low pulse on write chain output when last location written.
// - chained, low pulse on read chain output when last location read.
// - read data leave on an 18-bit bus.
// - full output low when full, writes then refused; clocked by write side.
// - reset clears pointers; full, almost-full high; empty, almost-empty low.
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "fsf_defs.vh"
module fsf_top (
    input wire clk_i,
    input wire rst_b_i,
    input wire wr_en_n_i,
    input wire [17:0] wr_data_i,
    input wire rd_en_n_i,
    output wire [17:0] rd_data_out_o,
    output reg empty_ind_n_o,
    output reg almost_empty_ind_n_o,
    output reg almost_full_ind_n_o,
    output reg full_ind_n_o,
    output reg wr_chain_out_n_o,
    output wire rd_chain_out_n_o,
    input wire wr_chain_in_n_i,
    input wire rd_chain_in_n_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg hreadyout_o,
    output reg hresp_o,
    output reg [31:0] hrdata_o,
    output reg irq_o
);
    // ==================================================
    // functions
    function [11:0] def_off;
        input [12:0] depth;
        begin
            if (depth < `FSF_DEPTH_D512) begin
                def_off = `FSF_OFF_D256;
            end else if (depth == `FSF_DEPTH_D512) begin
                def_off = `FSF_OFF_D512;
            end else begin
                def_off = `FSF_OFF_BIG;
            end
        end
    endfunction

    function [31:0] word12;
        input [11:0] v;
        begin
            word12 = {20'h00000, v};
        end
    endfunction

    // ==================================================
    // state
    reg [7:0] wr_ptr_q;
    reg [7:0] rd_ptr_q;
    reg [8:0] count_q;
    reg [8:0] count_d;
    reg half_full_ind_n_q;
    reg [1:0] ctrl_q;
    reg [11:0] ae_off_q;
    reg [11:0] af_off_q;
    reg [3:0] irq_stat_q;
    reg [3:0] irq_stat_d;
    reg [3:0] irq_mask_q;
    reg [7:0] bus_addr_q;
    reg bus_wr_q;
    wire wr_req;
    wire rd_req;
    wire wr_own;
    wire rd_own;
    wire do_wr;
    wire do_rd;
    wire exp_en;
    wire bus_take;
    wire rd_irq_now;
    wire [3:0] events;
    wire [12:0] af_sum;

    assign exp_en = ctrl_q[`FSF_CTRL_EXP];
    assign wr_req = ~wr_en_n_i;
    assign rd_req = ~rd_en_n_i;

    // ==================================================
    // accept writes and reads
    // writes stop at full, reads at empty; chained devices also need the token
    assign do_wr = wr_req & full_ind_n_o & (~exp_en | wr_own);
    assign do_rd = rd_req & empty_ind_n_o & (~exp_en | rd_own);

    // ==================================================
    // storage and tokens
    fsf_mem u_mem (
        .clk_i(clk_i),
        .wr_i(do_wr),
        .wr_addr_i(wr_ptr_q),
        .wr_data_i(wr_data_i),
        .rd_i(do_rd),
        .rd_addr_i(rd_ptr_q),
        .rd_data_q(rd_data_out_o)
    );

    fsf_chain_tok u_wr_tok (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .exp_en_i(exp_en),
        .first_load_i(ctrl_q[`FSF_CTRL_FL]),
        .last_done_i(do_wr & (wr_ptr_q == 8'hFF)),
        .chain_in_n_i(wr_chain_in_n_i),
        .own_q(wr_own),
        .chain_out_n_q() // shared pin is driven below, together with half-full
    );

    fsf_chain_tok u_rd_tok (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .exp_en_i(exp_en),
        .first_load_i(ctrl_q[`FSF_CTRL_FL]),
        .last_done_i(do_rd & (rd_ptr_q == 8'hFF)),
        .chain_in_n_i(rd_chain_in_n_i),
        .own_q(rd_own),
        .chain_out_n_q(rd_chain_out_n_o)
    );

    // ==================================================
    // next fill count
    always @* begin
        count_d = count_q;
        if (do_wr & ~do_rd) begin
            count_d = count_q + 9'h001;
        end else if (do_rd & ~do_wr) begin
            count_d = count_q - 9'h001;
        end
    end

    assign af_sum = {4'h0, count_d} + {1'b0, af_off_q};

    // ==================================================
    // pointers step on accepted requests; count and flags registered from the next count
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_q <= 8'h00;
            rd_ptr_q <= 8'h00;
            count_q <= 9'h000;
            empty_ind_n_o <= 1'b0;
            almost_empty_ind_n_o <= 1'b0;
            full_ind_n_o <= 1'b1;
            almost_full_ind_n_o <= 1'b1;
            half_full_ind_n_q <= 1'b1;
        end else begin
            if (do_wr) begin
                wr_ptr_q <= wr_ptr_q + 8'h01;
            end
            if (do_rd) begin
                rd_ptr_q <= rd_ptr_q + 8'h01;
            end
            count_q <= count_d;
            empty_ind_n_o <= (count_d != 9'h000);
            almost_empty_ind_n_o <= ({3'h0, count_d} > ae_off_q);
            full_ind_n_o <= (count_d != `FSF_DEPTH);
            almost_full_ind_n_o <= (af_sum < {4'h0, `FSF_DEPTH});
            half_full_ind_n_q <= ~(count_d > (`FSF_DEPTH >> 1));
        end
    end

    // ==================================================
    // shared pin: half-full alone, write chain pulse when expanded
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_chain_out_n_o <= 1'b1;
        end else if (exp_en) begin
            wr_chain_out_n_o <= ~(do_wr & (wr_ptr_q == 8'hFF));
        end else begin
            wr_chain_out_n_o <= half_full_ind_n_q;
        end
    end

    // ==================================================
    // ahb-lite slave: address phase capture
    assign bus_take = hsel_i & htrans_i[1] & hready_i;
    assign rd_irq_now = bus_take & ~hwrite_i & (haddr_i[7:0] == `FSF_A_IRQ)
        & (haddr_i[31:8] == 24'h000000);

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_addr_q <= 8'h00;
            bus_wr_q <= 1'b0;
            hreadyout_o <= 1'b1;
            hresp_o <= `FSF_RESP_OKAY;
        end else begin
            bus_wr_q <= bus_take & hwrite_i & (haddr_i[31:8] == 24'h000000);
            if (bus_take) begin
                bus_addr_q <= haddr_i[7:0];
            end
        end
    end

    // ==================================================
    // read data, latched during the address phase
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hrdata_o <= 32'h00000000;
        end else if (bus_take & ~hwrite_i) begin
            hrdata_o <= 32'h00000000;
            if (haddr_i[31:8] == 24'h000000) begin
                case (haddr_i[7:0])
                    `FSF_A_CTRL: begin
                        hrdata_o <= {30'h00000000, ctrl_q};
                    end
                    `FSF_A_AEOFF: begin
                        hrdata_o <= word12(ae_off_q);
                    end
                    `FSF_A_AFOFF: begin
                        hrdata_o <= word12(af_off_q);
                    end
                    `FSF_A_STAT: begin
                        hrdata_o <= {9'h000, rd_own, wr_own, half_full_ind_n_q,
                            full_ind_n_o, almost_full_ind_n_o, almost_empty_ind_n_o,
                            empty_ind_n_o, 7'h00, count_q};
                    end
                    `FSF_A_IRQ: begin
                        hrdata_o <= {28'h0000000, irq_stat_q};
                    end
                    `FSF_A_MASK: begin
                        hrdata_o <= {28'h0000000, irq_mask_q};
                    end
                    default: begin
                        hrdata_o <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // ==================================================
    // writable registers, stored in the data phase
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_q <= 2'h0;
            ae_off_q <= def_off({4'h0, `FSF_DEPTH});
            af_off_q <= def_off({4'h0, `FSF_DEPTH});
            irq_mask_q <= 4'h0;
        end else if (bus_wr_q) begin
            case (bus_addr_q)
                `FSF_A_CTRL: begin
                    ctrl_q <= hwdata_i[1:0];
                end
                `FSF_A_AEOFF: begin
                    ae_off_q <= hwdata_i[11:0];
                end
                `FSF_A_AFOFF: begin
                    af_off_q <= hwdata_i[11:0];
                end
                `FSF_A_MASK: begin
                    irq_mask_q <= hwdata_i[3:0];
                end
                default: begin
                    ctrl_q <= ctrl_q;
                end
            endcase
        end
    end

    // ==================================================
    // interrupt events: entering empty or full, refused write or read
    assign events[`FSF_EV_EMPTY] = empty_ind_n_o & (count_d == 9'h000);
    assign events[`FSF_EV_FULL] = full_ind_n_o & (count_d == `FSF_DEPTH);
    assign events[`FSF_EV_WREJ] = wr_req & ~do_wr;
    assign events[`FSF_EV_RREJ] = rd_req & ~do_rd;

    // read of the status clears it; an event in the same cycle survives
    always @* begin
        irq_stat_d = irq_stat_q;
        if (rd_irq_now) begin
            irq_stat_d = 4'h0;
        end
        irq_stat_d = irq_stat_d | events;
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_stat_q <= 4'h0;
            irq_o <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_o <= |(irq_stat_d & irq_mask_q);
        end
    end
endmodule

// file: core/fsf_defs.vh
// constants shared by the flag and expansion section of the 18-bit fifo
`ifndef FSF_DEFS_VH
`define FSF_DEFS_VH

// ==================================================
// storage geometry
`define FSF_DW 18
`define FSF_AW 8
`define FSF_DEPTH 9'h100
`define FSF_CW 9

// ==================================================
// reset offsets per depth variant
`define FSF_OFF_W 12
`define FSF_OFF_D256 12'h01F
`define FSF_OFF_D512 12'h03F
`define FSF_OFF_BIG 12'h07F
`define FSF_DEPTH_D512 13'h0200

// ==================================================
// register byte offsets on the bus
`define FSF_A_CTRL 8'h00
`define FSF_A_AEOFF 8'h04
`define FSF_A_AFOFF 8'h08
`define FSF_A_STAT 8'h0C
`define FSF_A_IRQ 8'h10
`define FSF_A_MASK 8'h14

// ==================================================
// field positions
`define FSF_CTRL_EXP 0
`define FSF_CTRL_FL 1
`define FSF_ST_EF 16
`define FSF_ST_AE 17
`define FSF_ST_AF 18
`define FSF_ST_FF 19
`define FSF_ST_HF 20
`define FSF_ST_WOWN 21
`define FSF_ST_ROWN 22
`define FSF_EV_W 4
`define FSF_EV_EMPTY 0
`define FSF_EV_FULL 1
`define FSF_EV_WREJ 2
`define FSF_EV_RREJ 3

// ==================================================
// ahb codes
`define FSF_RESP_OKAY 1'b0

`endif

// file: core/fsf_mem.v
// storage array of the fifo with a registered read port
`timescale 1ns/10ps
module fsf_mem (
    input wire clk_i,
    input wire wr_i,
    input wire [7:0] wr_addr_i,
    input wire [17:0] wr_data_i,
    input wire rd_i,
    input wire [7:0] rd_addr_i,
    output reg [17:0] rd_data_q
);
    reg [17:0] mem_q [0:255];

    // ==================================================
    // write port
    always @(posedge clk_i) begin
        if (wr_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // ==================================================
    // read port, output register holds the last word read
    always @(posedge clk_i) begin
        if (rd_i) begin
            rd_data_q <= mem_q[rd_addr_i];
        end
    end
endmodule

// file: core/fsf_chain_tok.v
// daisy-chain token for one port of a depth-expanded fifo
`timescale 1ns/10ps
module fsf_chain_tok (
    input wire clk_i,
    input wire rst_b_i,
    input wire exp_en_i,
    input wire first_load_i,
    input wire last_done_i,
    input wire chain_in_n_i,
    output reg own_q,
    output reg chain_out_n_q
);
    // ==================================================
    // token: held by first device, passed on after its last location
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            own_q <= 1'b0;
            chain_out_n_q <= 1'b1;
        end else begin
            chain_out_n_q <= ~(exp_en_i & last_done_i); // one-cycle low pulse
            if (!exp_en_i) begin
                own_q <= first_load_i;
            end else if (last_done_i) begin
                own_q <= 1'b0;
            end else if (!chain_in_n_i) begin
                own_q <= 1'b1; // previous device has filled or drained
            end
        end
    end
endmodule

// file: testbench/fsf_assertions.sv
// concurrent checks on the flag and bus ports of the fifo top
`timescale 1ns/10ps
module fsf_assertions (
    input wire clk_i,
    input wire rst_b_i,
    input wire wr_en_n_i,
    input wire rd_en_n_i,
    input wire empty_ind_n_o,
    input wire almost_empty_ind_n_o,
    input wire almost_full_ind_n_o,
    input wire full_ind_n_o,
    input wire rd_chain_out_n_o,
    input wire hreadyout_o,
    input wire hresp_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // ==================================================
    // a cycle with neither port requesting
    sequence s_idle;
        wr_en_n_i && rd_en_n_i;
    endsequence
    // ==================================================
    // fill state only moves on a request
    a_idle_hold: assert property (s_idle |=> $stable(empty_ind_n_o) && $stable(full_ind_n_o))
        else $error("flag moved without a request");
    a_empty_rise: assert property ($rose(empty_ind_n_o) |-> $past(!wr_en_n_i))
        else $error("empty cleared without a write");
    a_empty_fall: assert property ($fell(empty_ind_n_o) |-> $past(!rd_en_n_i))
        else $error("empty set without a read");
    a_full_fall: assert property ($fell(full_ind_n_o) |-> $past(!wr_en_n_i))
        else $error("full set without a write");
    a_full_rise: assert property ($rose(full_ind_n_o) |-> $past(!rd_en_n_i))
        else $error("full cleared without a read");
    // programmable flags must cover the fixed ones
    a_empty_ae: assert property (!empty_ind_n_o |-> !almost_empty_ind_n_o)
        else $error("empty without almost empty");
    a_full_af: assert property (!full_ind_n_o |-> !almost_full_ind_n_o)
        else $error("full without almost full");
    a_rd_pulse: assert property ($fell(rd_chain_out_n_o) |=> rd_chain_out_n_o)
        else $error("read chain pulse too long");
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or not okay");
endmodule

// file: testbench/fsf_tb_chain.sv
// chain neighbour that hands each expansion pulse back after a delay
`timescale 1ns/10ps
module fsf_tb_chain #(
    parameter LAT = 3
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire wr_chain_out_n_i,
    input wire rd_chain_out_n_i,
    output wire wr_chain_in_n_o,
    output wire rd_chain_in_n_o
);
    reg [7:0] wr_seen_q;
    reg [7:0] rd_seen_q;
    // delay line of the low level on each chain output
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_seen_q <= 8'h00;
            rd_seen_q <= 8'h00;
        end else begin
            wr_seen_q <= {wr_seen_q[6:0], ~wr_chain_out_n_i};
            rd_seen_q <= {rd_seen_q[6:0], ~rd_chain_out_n_i};
        end
    end
    // one low cycle back, LAT+1 cycles after the pulse began
    assign wr_chain_in_n_o = ~(wr_seen_q[LAT] & ~wr_seen_q[LAT+1]);
    assign rd_chain_in_n_o = ~(rd_seen_q[LAT] & ~rd_seen_q[LAT+1]);
endmodule

// file: testbench/tb_top.sv
// top testbench of the fifo flag section with its chain partner
`timescale 1ns/10ps
`include "fsf_defs.vh"
module tb_top;
    reg clk_i = 1'b0;
    reg rst_b_i = 1'b0;
    reg wr_en_n_i = 1'b1;
    reg rd_en_n_i = 1'b1;
    reg [17:0] wr_data_i = 18'h00000;
    reg [31:0] haddr_i = 32'h00000000;
    reg [1:0] htrans_i = 2'h0;
    reg hwrite_i = 1'b0;
    reg [31:0] hwdata_i = 32'h00000000;
    reg [31:0] rdv;
    wire [17:0] rd_data_out_o;
    wire empty_ind_n_o, almost_empty_ind_n_o, almost_full_ind_n_o, full_ind_n_o;
    wire wr_chain_out_n_o, rd_chain_out_n_o, wr_chain_in_n_i, rd_chain_in_n_i;
    wire hreadyout_o, hresp_o, irq_o;
    wire [31:0] hrdata_o;
    integer mismatches = 0;
    integer tests_run = 0;
    integer cnt = 0;
    integer exp_mode = 0;
    integer wr_pulses = 0;
    integer rd_pulses = 0;
    integer i;
    // ==================================================
    // clock, pulse counters, watchdog
    always #10 clk_i = ~clk_i;
    always @(negedge wr_chain_out_n_o) if (exp_mode) wr_pulses = wr_pulses + 1;
    always @(negedge rd_chain_out_n_o) rd_pulses = rd_pulses + 1;
    initial begin
        #1500000;
        mismatches = mismatches + 1;
        report_and_stop;
    end
    fsf_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .wr_en_n_i(wr_en_n_i),
        .wr_data_i(wr_data_i), .rd_en_n_i(rd_en_n_i), .rd_data_out_o(rd_data_out_o),
        .empty_ind_n_o(empty_ind_n_o), .almost_empty_ind_n_o(almost_empty_ind_n_o),
        .almost_full_ind_n_o(almost_full_ind_n_o), .full_ind_n_o(full_ind_n_o),
        .wr_chain_out_n_o(wr_chain_out_n_o), .rd_chain_out_n_o(rd_chain_out_n_o),
        .wr_chain_in_n_i(wr_chain_in_n_i), .rd_chain_in_n_i(rd_chain_in_n_i),
        .hsel_i(1'b1), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .irq_o(irq_o));
    fsf_tb_chain #(.LAT(3)) u_chain (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .wr_chain_out_n_i(wr_chain_out_n_o), .rd_chain_out_n_i(rd_chain_out_n_o),
        .wr_chain_in_n_o(wr_chain_in_n_i), .rd_chain_in_n_o(rd_chain_in_n_i));
    // ==================================================
    // shared tasks
    task chk(input string what, input [31:0] e, input [31:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("MISMATCH %s expected %h seen %h", what, e, g);
            end
        end
    endtask
    task ahb(input w, input [31:0] a, input [31:0] d, output [31:0] r);
        begin
            @(posedge clk_i);
            htrans_i <= 2'h2;
            haddr_i <= a;
            hwrite_i <= w;
            do @(posedge clk_i); while (hreadyout_o !== 1'b1);
            htrans_i <= 2'h0;
            hwdata_i <= d;
            do @(posedge clk_i); while (hreadyout_o !== 1'b1);
            r = hrdata_o;
            @(negedge clk_i);
        end
    endtask
    // one request cycle, one idle cycle so the late half-full lands
    task cyc(input w, input r, input [17:0] d);
        begin
            @(posedge clk_i);
            wr_en_n_i <= !w;
            rd_en_n_i <= !r;
            wr_data_i <= d;
            @(posedge clk_i);
            wr_en_n_i <= 1'b1;
            rd_en_n_i <= 1'b1;
            @(posedge clk_i);
            @(negedge clk_i);
        end
    endtask
    task flags;
        begin
            chk("empty", cnt != 0, empty_ind_n_o);
            chk("almost_empty", cnt > 31, almost_empty_ind_n_o);
            chk("almost_full", cnt < 225, almost_full_ind_n_o);
            chk("full", cnt != 256, full_ind_n_o);
            if (exp_mode == 0) chk("half_full", cnt <= 128, wr_chain_out_n_o);
        end
    endtask
    // ==================================================
    // scenarios
    task t_reset;
        begin
            flags;
            chk("rd_chain", 1, rd_chain_out_n_o);
            ahb(0, `FSF_A_AEOFF, 0, rdv);
            chk("ae_offset", 32'h0000001F, rdv);
            ahb(0, `FSF_A_AFOFF, 0, rdv);
            chk("af_offset", 32'h0000001F, rdv);
            ahb(0, `FSF_A_STAT, 0, rdv);
            chk("status", 32'h001C0000, rdv);
            ahb(0, 32'h00000020, 0, rdv);
            chk("unmapped", 32'h00000000, rdv);
        end
    endtask
    task t_irq;
        begin
            cyc(0, 1, 18'h00000);
            chk("irq_masked", 0, irq_o);
            ahb(1, `FSF_A_MASK, 32'h0000000F, rdv);
            // the interrupt output follows the new mask one edge later
            @(negedge clk_i);
            chk("irq_raised", 1, irq_o);
            ahb(0, `FSF_A_IRQ, 0, rdv);
            chk("irq_status", 32'h00000008, rdv);
            chk("irq_cleared", 0, irq_o);
        end
    endtask
    task t_round;
        begin
            for (i = 0; i < 256; i = i + 1) begin
                cyc(1, 0, 18'h2D000 + i[17:0]);
                cnt = cnt + 1;
                flags;
            end
            cyc(1, 0, 18'h3FFFF);
            flags;
            ahb(0, `FSF_A_IRQ, 0, rdv);
            chk("irq_fill", 32'h00000006, rdv);
            for (i = 0; i < 256; i = i + 1) begin
                cyc(0, 1, 18'h00000);
                cnt = cnt - 1;
                chk("rd_data", 18'h2D000 + i[17:0], rd_data_out_o);
                flags;
            end
            cyc(0, 1, 18'h00000);
            chk("rd_data_held", 18'h2D0FF, rd_data_out_o);
            ahb(0, `FSF_A_IRQ, 0, rdv);
            chk("irq_drain", 32'h00000009, rdv);
        end
    endtask
    task t_chain;
        begin
            exp_mode = 1;
            rd_pulses = 0;
            // tokens load from first-load only while expansion is still off
            ahb(1, `FSF_A_CTRL, 32'h00000002, rdv);
            ahb(1, `FSF_A_CTRL, 32'h00000003, rdv);
            t_round;
            chk("wr_pulses", 1, wr_pulses);
            chk("rd_pulses", 1, rd_pulses);
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, mismatches);
            if (mismatches == 0 && tests_run > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // ==================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(negedge clk_i);
        t_reset;
        t_irq;
        t_round;
        chk("rd_no_pulse", 0, rd_pulses);
        t_chain;
        report_and_stop;
    end
endmodule
bind fsf_top fsf_assertions u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .wr_en_n_i(wr_en_n_i), .rd_en_n_i(rd_en_n_i), .empty_ind_n_o(empty_ind_n_o),
    .almost_empty_ind_n_o(almost_empty_ind_n_o), .almost_full_ind_n_o(almost_full_ind_n_o),
    .full_ind_n_o(full_ind_n_o), .rd_chain_out_n_o(rd_chain_out_n_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));
